// >>> common/posf_pkg.sv
/*
 Shared constants and types for the packet framer: register map, control bits,
 event bits, octet codes, CRC constants and the state record.
 Assumes a single clock domain and a 32-bit register bus.
*/
package posf_pkg;
	// ==========================================
	// Register map and reset values
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_ACF = 8'h08;
	localparam logic [7:0] OFF_PRF = 8'h0C;
	localparam logic [7:0] OFF_RXCNT = 8'h10;
	localparam logic [7:0] OFF_ERRCNT = 8'h14;
	localparam logic [7:0] OFF_ISTAT = 8'h18;
	localparam logic [7:0] OFF_IMASK = 8'h1C;
	localparam logic [15:0] RST_ACF = 16'hFF03;
	localparam logic [15:0] RST_PRF = 16'h0021;
	// ==========================================
	// Control and event bit positions
	localparam int C_F32 = 0;
	localparam int C_CMP = 1;
	localparam int C_TRN = 2;
	localparam int C_DSC = 3;
	localparam int C_TEN = 4;
	localparam int E_ABT = 0;
	localparam int E_CRC = 1;
	localparam int E_SHT = 2;
	localparam int E_LNG = 3;
	localparam int E_ACE = 4;
	localparam int E_PRE = 5;
	localparam int E_DRP = 6;
	localparam int CNT_W = 32;
	// ==========================================
	// Octets and check sequence constants
	localparam logic [7:0] FLAG = 8'h7E;
	localparam logic [7:0] ESC = 8'h7D;
	localparam logic [7:0] ESC_X = 8'h20;
	localparam logic [31:0] POLY16 = 32'h0000_8408;
	localparam logic [31:0] POLY32 = 32'hEDB8_8320;
	localparam logic [31:0] INIT16 = 32'h0000_FFFF;
	localparam logic [31:0] INIT32 = 32'hFFFF_FFFF;
	localparam logic [31:0] RES16 = 32'h0000_F0B8;
	localparam logic [31:0] RES32 = 32'hDEBB_20E3;
	localparam logic [2:0] FCS16_LEN = 3'h2;
	localparam logic [2:0] FCS32_LEN = 3'h4;
	localparam logic [2:0] AC_LEN = 3'h2;
	// ==========================================
	// State
	typedef enum logic [3:0] {
		POSF_TX_IDLE = 4'b0001,
		POSF_TX_HDR = 4'b0010,
		POSF_TX_DATA = 4'b0100,
		POSF_TX_FCS = 4'b1000
	} posf_txs_t;

	typedef struct packed {
		logic [4:0] ctrl;
		logic [7:0] nflag;
		logic [15:0] acf;
		logic [15:0] prf;
		logic [6:0] ist;
		logic [6:0] imsk;
		logic [CNT_W-1:0] rxc;
		logic [CNT_W-1:0] erc;
		logic aw;
		logic [7:0] aa;
		logic [31:0] rd;
		posf_txs_t ts;
		logic [8:0] gap;
		logic [2:0] idx;
		logic esc;
		logic [7:0] pend;
		logic [7:0] tdat;
		logic [31:0] tcrc;
		logic inf;
		logic resc;
		logic [15:0] cnt;
		logic [2:0] ridx;
		logic [2:0] fill;
		logic [31:0] dly;
		logic [31:0] rcrc;
		logic ace;
		logic pre;
		logic [7:0] odat;
		logic oval;
		logic oend;
		logic oerr;
		logic [6:0] ind;
	} posf_st_t;
endpackage

// >>> hdl/posf_framer.sv
/*
 Packet framer with octet stuffing and check sequence, transmit and receive,
 with an AHB-Lite register slave and one interrupt line.
 Assumes the packet FIFO and the line framer run on the same clock.
*/
module posf_framer #(
	parameter logic [15:0] MIN_LEN = 16'h0004,
	parameter logic [15:0] MAX_LEN = 16'h05DC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	// Transmit FIFO side
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	// Line side
	output logic [7:0] line_tx_data,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	// Receive output
	output logic [7:0] rx_out_data,
	output logic rx_out_valid,
	output logic rx_out_end,
	output logic rx_out_err,
	output logic [6:0] rx_ind
);
	import posf_pkg::*;

	posf_st_t q, d;
	logic [7:0] oct, rb;
	logic raw, tk, f32, dsc;
	logic [34:0] hd;
	logic [2:0] fl;
	logic [15:0] ovh;
	logic [6:0] ev;

	// ==========================================
	// Helpers
	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b,
		input logic w32);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ (w32 ? POLY32 : POLY16);
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// Header octets, first in the low byte, and their count in the top bits.
	function automatic logic [34:0] hdr(input logic [4:0] c, input logic [15:0] a,
		input logic [15:0] p);
		logic [34:0] h;
		if (c[C_CMP]) begin
			h = {(c[C_TRN] ? 3'h0 : 3'h1), 24'h0, p[7:0]};
		end else begin
			h = {(c[C_TRN] ? AC_LEN : 3'h4), p[7:0], p[15:8], a[7:0], a[15:8]};
		end
		return h;
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rd;
	assign irq = |(q.ist & q.imsk);
	assign line_tx_data = q.tdat;
	assign rx_out_data = q.odat;
	assign rx_out_valid = q.oval;
	assign rx_out_end = q.oend;
	assign rx_out_err = q.oerr;
	assign rx_ind = q.ind;

	// ==========================================
	// Next state
	always_comb begin
		d = q;
		tx_ready = 1'b0;
		oct = FLAG;
		rb = 8'h00;
		raw = 1'b0;
		tk = 1'b0;
		ev = '0;
		f32 = q.ctrl[C_F32];
		dsc = q.ctrl[C_DSC];
		fl = f32 ? FCS32_LEN : FCS16_LEN;
		hd = hdr(q.ctrl, q.acf, q.prf);
		ovh = {13'h0, hd[34:32]} + {13'h0, fl};
		d.oval = 1'b0;
		d.oend = 1'b0;
		d.oerr = 1'b0;
		d.ind = '0;
		// Register writes land in the data phase; status clears before events are merged.
		d.aw = hsel && htrans[1] && hready && hwrite;
		d.aa = haddr[7:0];
		if (q.aw) begin
			case (q.aa)
				OFF_CTRL: d.ctrl = hwdata[4:0];
				OFF_FLAGS: d.nflag = hwdata[7:0];
				OFF_ACF: d.acf = hwdata[15:0];
				OFF_PRF: d.prf = hwdata[15:0];
				OFF_ISTAT: d.ist = q.ist & ~hwdata[6:0];
				OFF_IMASK: d.imsk = hwdata[6:0];
				default: d.ist = d.ist;
			endcase
		end
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				OFF_CTRL: d.rd = {27'h0, q.ctrl};
				OFF_FLAGS: d.rd = {24'h0, q.nflag};
				OFF_ACF: d.rd = {16'h0, q.acf};
				OFF_PRF: d.rd = {16'h0, q.prf};
				OFF_RXCNT: d.rd = q.rxc;
				OFF_ERRCNT: d.rd = q.erc;
				OFF_ISTAT: d.rd = {25'h0, q.ist};
				OFF_IMASK: d.rd = {25'h0, q.imsk};
				default: d.rd = 32'h0000_0000;
			endcase
		end

		// Transmit: one line octet every clock; a stuffed octet holds the sequence.
		if (q.esc) begin
			d.tdat = q.pend ^ ESC_X;
			d.esc = 1'b0;
		end else begin
			case (q.ts)
				POSF_TX_IDLE: begin
					raw = 1'b1;
					if (q.gap != 9'h1FF) begin
						d.gap = q.gap + 9'h001;
					end
					if (q.gap >= {1'b0, q.nflag} && q.ctrl[C_TEN] && tx_valid) begin
						d.ts = POSF_TX_HDR;
						d.idx = 3'h0;
						d.tcrc = f32 ? INIT32 : INIT16;
					end
				end
				POSF_TX_HDR: begin
					if (q.idx < hd[34:32]) begin
						oct = hd[{q.idx[1:0], 3'b000} +: 8];
						d.tcrc = crc_upd(q.tcrc, oct, f32);
						d.idx = q.idx + 3'h1;
					end else begin
						tk = 1'b1;
					end
				end
				POSF_TX_DATA: tk = 1'b1;
				POSF_TX_FCS: begin
					oct = ~q.tcrc[{q.idx[1:0], 3'b000} +: 8];
					d.idx = q.idx + 3'h1;
					if (q.idx == fl - 3'h1) begin
						d.ts = POSF_TX_IDLE;
						d.gap = 9'h000;
					end
				end
				default: d.ts = POSF_TX_IDLE;
			endcase
			if (tk) begin
				if (tx_valid) begin
					tx_ready = 1'b1;
					oct = tx_data;
					d.tcrc = crc_upd(q.tcrc, oct, f32);
					d.ts = tx_last ? POSF_TX_FCS : POSF_TX_DATA;
					d.idx = 3'h0;
				end else begin
					// An empty FIFO mid-packet aborts it: escape then the idle flag.
					oct = ESC;
					raw = 1'b1;
					d.ts = POSF_TX_IDLE;
					d.gap = 9'h000;
				end
			end
			if (!raw && (oct == FLAG || oct == ESC)) begin
				d.tdat = ESC;
				d.pend = oct;
				d.esc = 1'b1;
			end else begin
				d.tdat = oct;
			end
		end

		// Receive
		if (rx_valid) begin
			if (rx_data == FLAG) begin
				if (q.inf && (q.cnt != 16'h0000 || q.resc)) begin
					ev[E_ABT] = q.resc;
					ev[E_CRC] = !q.resc && q.rcrc != (f32 ? RES32 : RES16);
					ev[E_SHT] = q.cnt < ovh + MIN_LEN;
					ev[E_LNG] = q.cnt > ovh + MAX_LEN;
					ev[E_ACE] = q.ace;
					ev[E_PRE] = q.pre;
					ev[E_DRP] = dsc && (q.ace || q.pre);
					d.ind = ev;
					d.oend = 1'b1;
					d.oerr = |ev;
					d.rxc = q.rxc + 1'b1;
					if (|ev) begin
						d.erc = q.erc + 1'b1;
					end
				end
				d.inf = 1'b1;
				d.resc = 1'b0;
				d.cnt = 16'h0000;
				d.ridx = 3'h0;
				d.fill = 3'h0;
				d.ace = 1'b0;
				d.pre = 1'b0;
				d.rcrc = f32 ? INIT32 : INIT16;
			end else if (q.inf) begin
				if (rx_data == ESC && !q.resc) begin
					d.resc = 1'b1;
				end else begin
					rb = rx_data ^ (q.resc ? ESC_X : 8'h00);
					d.resc = 1'b0;
					d.rcrc = crc_upd(q.rcrc, rb, f32);
					if (q.cnt != 16'hFFFF) begin
						d.cnt = q.cnt + 16'h0001;
					end
					if (q.ridx < hd[34:32]) begin
						d.ridx = q.ridx + 3'h1;
						if (rb != hd[{q.ridx[1:0], 3'b000} +: 8]) begin
							if (!q.ctrl[C_CMP] && q.ridx < AC_LEN) begin
								d.ace = 1'b1;
							end else begin
								d.pre = 1'b1;
							end
						end
					end else begin
						// The last fl octets may be the check sequence, so hold them back.
						d.dly = {q.dly[23:0], rb};
						if (q.fill == fl) begin
							d.odat = q.dly[{fl[1:0] - 2'h1, 3'b000} +: 8];
							d.oval = !(dsc && (q.ace || q.pre));
						end else begin
							d.fill = q.fill + 3'h1;
						end
					end
				end
			end
		end
		d.ist = d.ist | ev;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			q <= '0;
			q.ts <= POSF_TX_IDLE;
			q.acf <= RST_ACF;
			q.prf <= RST_PRF;
			q.tdat <= FLAG;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// Checks
	sequence s_abort_seq;
		rx_valid && rx_data == ESC ##1 rx_valid && rx_data == FLAG;
	endsequence

	a_abort_ind: assert property (@(posedge clock) disable iff (!rst_b)
		(q.inf && !q.resc) ##0 s_abort_seq |=> rx_ind[E_ABT] && rx_out_end)
		else $error("abort sequence not indicated");
	a_irq_follow: assert property (@(posedge clock) disable iff (!rst_b)
		(|(rx_ind & q.imsk)) |-> irq)
		else $error("masked-in event did not raise irq");
	a_tx_no_flag: assert property (@(posedge clock) disable iff (!rst_b)
		tx_ready |=> line_tx_data != FLAG)
		else $error("flag octet leaked into packet");
	a_esc_first: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(q.esc) |-> line_tx_data == ESC)
		else $error("stuffing did not start with escape");
	a_esc_xor: assert property (@(posedge clock) disable iff (!rst_b)
		q.esc |=> line_tx_data == ($past(q.pend) ^ ESC_X))
		else $error("stuffed octet not xored");
	a_flag_gap: assert property (@(posedge clock) disable iff (!rst_b)
		(q.ts == POSF_TX_IDLE && q.gap < {1'b0, q.nflag}) |=> q.ts == POSF_TX_IDLE)
		else $error("packet started before flag gap");
	a_rx_count: assert property (@(posedge clock) disable iff (!rst_b)
		rx_out_end |-> q.rxc == $past(q.rxc) + 1'b1)
		else $error("packet counter did not advance");
	a_err_hold: assert property (@(posedge clock) disable iff (!rst_b)
		(rx_out_end && !rx_out_err) |-> q.erc == $past(q.erc))
		else $error("error counter moved on good packet");
	a_drop_quiet: assert property (@(posedge clock) disable iff (!rst_b)
		(q.ctrl[C_DSC] && (q.ace || q.pre) && !(rx_valid && rx_data == FLAG))
		|=> !rx_out_valid)
		else $error("discarded packet passed out");

	// Software counts one end pulse per frame, so indications may only ride on it.
	a_ind_end: assert property (@(posedge clock) disable iff (!rst_b)
		(|rx_ind) |-> rx_out_end)
		else $error("indication without packet end");
	a_end_pulse: assert property (@(posedge clock) disable iff (!rst_b)
		rx_out_end |=> !rx_out_end)
		else $error("packet end longer than one cycle");
	a_len_excl: assert property (@(posedge clock) disable iff (!rst_b)
		rx_out_end |-> !(rx_ind[E_SHT] && rx_ind[E_LNG]))
		else $error("packet both short and long");
	// A stretched escape would swallow the octet that follows it.
	a_esc_once: assert property (@(posedge clock) disable iff (!rst_b)
		q.esc |=> !q.esc)
		else $error("escape held for two octets");
	a_pop_valid: assert property (@(posedge clock) disable iff (!rst_b)
		tx_ready |-> tx_valid && !q.esc)
		else $error("byte taken from empty fifo");
	a_fcs_len: assert property (@(posedge clock) disable iff (!rst_b)
		(q.ts == POSF_TX_FCS) |-> q.idx < fl)
		else $error("check sequence overran its length");
endmodule

// >>> tb/posf_line_model.sv
/*
 Far side model: a byte FIFO that feeds payload on the pop handshake, and a
 line framer that loops transmitted octets back into the receive side.
 Assumes one shared clock; corruption is applied only when the bench asks.
*/
module posf_line_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// FIFO side
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_last,
	input wire logic tx_ready,
	// Line side
	input wire logic [7:0] line_tx_data,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic corrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] mem [0:63];
	logic [5:0] rp = 6'h00;
	logic [5:0] wp = 6'h00;
	logic arm = 1'b0;
	assign tx_valid = rp != wp;
	assign tx_data = mem[rp][7:0];
	assign tx_last = mem[rp][8];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h7E;
	end
	task automatic push(input logic [7:0] d, input logic l);
		mem[wp] = {l, d};
		wp = wp + 6'h01;
	endtask
	// ==========================================
	// Loop back
	// Corruption is one-shot, so only the first octet of one frame is hit.
	always @(posedge clock) begin
		if (tx_valid && tx_ready) rp <= rp + 6'h01;
		rx_valid <= rst_b;
		rx_data <= (arm && line_tx_data != 8'h7E) ? line_tx_data ^ 8'h01 : line_tx_data;
		if (corrupt) arm <= 1'b1;
		else if (line_tx_data != 8'h7E) arm <= 1'b0;
	end
endmodule

// >>> tb/posf_framer_tb.sv
/*
 Self-checking bench for the framer: registers over AHB-Lite, frames looped
 from transmit to receive through the line model.
 Assumes zero wait states are not relied on; every wait is bounded.
*/
module posf_framer_tb;
	import posf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic corrupt = 1'b0;
	logic hreadyout, hresp, irq, tx_ready, tx_valid, tx_last, rx_valid;
	logic rx_out_valid, rx_out_end, rx_out_err, err_q;
	logic [31:0] hrdata, rd;
	logic [7:0] tx_data, line_tx_data, rx_data, rx_out_data;
	logic [7:0] last_oct = 8'h7E;
	logic [7:0] hdr0 = 8'h00;
	logic [6:0] rx_ind, ind_q;
	logic [7:0] got [$];
	logic [7:0] pkt [0:7];
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int ends = 0;
	int run = 0;
	int gap_run = 0;
	int esc_n = 0;
	int esc_bad = 0;
	// A low long-packet limit keeps an over-length frame inside the model's FIFO.
	localparam logic [15:0] TB_MAX_LEN = 16'h0006;
	initial begin
		forever #20 clock = ~clock;
	end
	posf_framer #(.MAX_LEN(TB_MAX_LEN)) u_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.line_tx_data(line_tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_out_end(rx_out_end),
		.rx_out_err(rx_out_err), .rx_ind(rx_ind));
	posf_line_model u_line (.clock(clock), .rst_b(rst_b), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.line_tx_data(line_tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
		.corrupt(corrupt));
	// ==========================================
	// Monitor and watchdog
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			results();
		end
		if (rx_out_valid === 1'b1) got.push_back(rx_out_data);
		if (rx_out_end === 1'b1) begin
			ind_q = rx_ind;
			err_q = rx_out_err;
			ends++;
		end
		if (last_oct === ESC && line_tx_data !== 8'h5E && line_tx_data !== 8'h5D) esc_bad++;
		if (line_tx_data === ESC) esc_n++;
		if (line_tx_data === FLAG) begin
			run++;
		end else begin
			if (run > 0) begin
				gap_run = run;
				hdr0 = line_tx_data;
			end
			run = 0;
		end
		last_oct = line_tx_data;
	end
	// ==========================================
	// Shared tasks
	task automatic results();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic chk_pay(input int n);
		chk(got.size(), n, "payload length");
		for (int i = 0; i < n && i < got.size(); i++) chk(got[i], pkt[i], "payload byte");
	endtask
	task automatic chk_irq(input logic e);
		@(negedge clock);
		chk(irq, e, "irq");
		@(posedge clock);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// Packets are queued whole, k copies, then the bench waits for k closing pulses.
	// Filling the FIFO off the edge keeps its flags from racing the design's sampling edge.
	task automatic send(input int n, input int k, input logic lst);
		int target;
		target = ends + k;
		got.delete();
		esc_n = 0;
		esc_bad = 0;
		@(negedge clock);
		for (int j = 0; j < k; j++) begin
			for (int i = 0; i < n; i++) u_line.push(pkt[i], lst && i == n - 1);
		end
		for (int i = 0; i < 3000 && ends < target; i++) @(negedge clock);
		@(posedge clock);
		chk(ends, target, "frame end");
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		bus(0, OFF_CTRL, 0, rd);
		chk(rd, 0, "ctrl reset");
		bus(0, OFF_ACF, 0, rd);
		chk(rd, {16'h0, RST_ACF}, "acf reset");
		bus(0, OFF_PRF, 0, rd);
		chk(rd, {16'h0, RST_PRF}, "prf reset");
		bus(0, 8'h20, 0, rd);
		chk(rd, 0, "unmapped read");
		chk_irq(1'b0);
	endtask
	task automatic t_modes();
		logic [4:0] c;
		logic [15:0] a;
		for (int i = 0; i < 4; i++) begin
			c = (i == 0) ? 5'h10 : 5'h10 | (5'h01 << (i - 1));
			a = (i == 3) ? 16'h8F01 : RST_ACF;
			bus(1, OFF_ACF, {16'h0, a}, rd);
			bus(1, OFF_CTRL, {27'h0, c}, rd);
			send(5, 1, 1'b1);
			chk_pay(5);
			chk(ind_q, 0, "clean indications");
			chk(hdr0, c[C_CMP] ? RST_PRF[7:0] : a[15:8], "first header octet");
			chk(esc_bad, 0, "escape form");
			chk(esc_n >= 2, 1, "escapes sent");
		end
		bus(0, OFF_RXCNT, 0, rd);
		chk(rd, 4, "packet count");
		bus(0, OFF_ERRCNT, 0, rd);
		chk(rd, 0, "error count");
	endtask
	task automatic t_short();
		send(2, 1, 1'b1);
		chk(ind_q[E_SHT], 1, "short flag");
		chk(err_q, 1, "error flag");
	endtask
	task automatic t_ace();
		bus(1, OFF_CTRL, 32'h18, rd);
		corrupt <= 1'b1;
		@(posedge clock);
		corrupt <= 1'b0;
		send(5, 1, 1'b1);
		chk(ind_q[E_ACE], 1, "header error");
		chk(ind_q[E_CRC], 1, "check error");
		chk(got.size(), 0, "discarded");
		bus(0, OFF_ERRCNT, 0, rd);
		chk(rd, 2, "error count");
		chk_irq(1'b0);
		bus(1, OFF_IMASK, 32'h1 << E_ACE, rd);
		bus(0, OFF_ISTAT, 0, rd);
		chk(rd[E_ACE], 1, "status bit");
		chk_irq(1'b1);
		bus(1, OFF_ISTAT, 32'h7F, rd);
		bus(0, OFF_ISTAT, 0, rd);
		chk(rd, 0, "status cleared");
		chk_irq(1'b0);
	endtask
	task automatic t_gap();
		bus(1, OFF_CTRL, 32'h10, rd);
		for (int f = 0; f < 256; f += 255) begin
			bus(1, OFF_FLAGS, f, rd);
			send(4, 2, 1'b1);
			chk(gap_run, f + 1, "flags between packets");
		end
	endtask
	task automatic t_long();
		bus(1, OFF_CTRL, 32'h12, rd);
		corrupt <= 1'b1;
		@(posedge clock);
		corrupt <= 1'b0;
		send(7, 1, 1'b1);
		chk(ind_q[E_LNG], 1, "long flag");
		chk(ind_q[E_PRE], 1, "protocol error");
		chk(ind_q[E_ACE], 0, "no header error");
		chk_pay(7);
	endtask
	task automatic t_abort();
		bus(1, OFF_IMASK, 32'h1 << E_ABT, rd);
		bus(1, OFF_CTRL, 32'h10, rd);
		send(3, 1, 1'b0);
		chk(ind_q[E_ABT], 1, "abort flag");
		chk(err_q, 1, "abort is an error");
		chk_irq(1'b1);
		bus(1, OFF_ISTAT, 32'h7F, rd);
		chk_irq(1'b0);
	endtask
	initial begin
		pkt = '{8'h7E, 8'h11, 8'h7D, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_modes();
		t_short();
		t_ace();
		t_long();
		t_abort();
		t_gap();
		results();
	end
endmodule
